/* hw/chac_top.sv */
`timescale 1ns/10ps
module chac_top
  import chac_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  // Register access from the serial host interface
  input wire logic REG_WR_EN_IN,
  input wire logic REG_RD_EN_IN,
  input wire logic [CHAC_ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [CHAC_DATA_W-1:0] REG_WDATA_IN,
  output logic [CHAC_DATA_W-1:0] REG_RDATA_OUT,
  // Device status feeding back
  input wire logic CMD_DONE_IN,
  input wire logic WAKE_IN,
  // Command and power controls
  output logic [CHAC_CMD_W-1:0] CMD_CODE_OUT,
  output logic CMD_START_OUT,
  output logic STANDBY_OUT,
  output logic RADIO_FRONTEND_POWER_DOWN_OUT,
  // Bus arbitration and link select
  output logic WRITE_UNLOCK_OUT,
  output logic HOST_BUS_GRANT_OUT,
  output logic SECURE_MODULE_BUS_GRANT_OUT,
  output logic [3:0] SECURE_MODULE_LINK_EN_OUT
);
  typedef struct packed {
    logic standby;
    logic radio_pd;
    logic [CHAC_CMD_W-1:0] cmd;
    logic cmd_start;
    logic unlock;
    logic host_grant;
    logic secure_grant;
    chac_link_type link_sel;
    logic [CHAC_DATA_W-1:0] rdata;
  } chac_state_type;

  chac_state_type st_r;
  chac_state_type st_nxt;
  logic wr_cmd;
  logic wr_host;
  logic new_host;
  logic new_secure;

  assign wr_cmd = REG_WR_EN_IN && (REG_ADDR_IN == CHAC_ADDR_COMMAND);
  assign wr_host = REG_WR_EN_IN && (REG_ADDR_IN == CHAC_ADDR_HOST_ACCESS);
  assign new_host = REG_WDATA_IN[CHAC_HOST_GRANT_BIT];
  assign new_secure = REG_WDATA_IN[CHAC_SECURE_GRANT_BIT];

  always_comb begin
    st_nxt = st_r;
    st_nxt.cmd_start = 1'b0;
    // Completion returns the field to idle; a write in the same cycle wins
    if (CMD_DONE_IN) begin
      st_nxt.cmd = CHAC_CMD_IDLE;
    end
    if (WAKE_IN) begin
      st_nxt.standby = 1'b0;
    end
    if (wr_cmd) begin
      st_nxt.standby = REG_WDATA_IN[CHAC_STANDBY_BIT];
      st_nxt.radio_pd = REG_WDATA_IN[CHAC_RADIO_PD_BIT];
      st_nxt.cmd = REG_WDATA_IN[CHAC_CMD_MSB:CHAC_CMD_LSB];
      st_nxt.cmd_start = 1'b1;
    end
    // Any write consumes a pending unlock
    if (REG_WR_EN_IN && st_r.unlock) begin
      st_nxt.unlock = 1'b0;
    end
    if (wr_host) begin
      if (st_r.unlock) begin
        st_nxt.link_sel = chac_link_type'(REG_WDATA_IN[CHAC_LINK_MSB:CHAC_LINK_LSB]);
        // A request for both grants leaves the grants as they were
        if (!(new_host && new_secure)) begin
          st_nxt.host_grant = new_host;
          st_nxt.secure_grant = new_secure;
        end
      end else begin
        st_nxt.unlock = REG_WDATA_IN[CHAC_UNLOCK_BIT];
      end
    end
    if (REG_RD_EN_IN) begin
      st_nxt.rdata = CHAC_ZERO_BYTE;
      if (REG_ADDR_IN == CHAC_ADDR_COMMAND) begin
        st_nxt.rdata[CHAC_STANDBY_BIT] = st_r.standby;
        st_nxt.rdata[CHAC_RADIO_PD_BIT] = st_r.radio_pd;
        st_nxt.rdata[CHAC_CMD_MSB:CHAC_CMD_LSB] = st_r.cmd;
      end else if (REG_ADDR_IN == CHAC_ADDR_HOST_ACCESS) begin
        st_nxt.rdata[CHAC_UNLOCK_BIT] = st_r.unlock;
        st_nxt.rdata[CHAC_HOST_GRANT_BIT] = st_r.host_grant;
        st_nxt.rdata[CHAC_SECURE_GRANT_BIT] = st_r.secure_grant;
        st_nxt.rdata[CHAC_LINK_MSB:CHAC_LINK_LSB] = st_r.link_sel;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_r <= '{standby: 1'b0, radio_pd: 1'b0, cmd: CHAC_CMD_IDLE, cmd_start: 1'b0,
                unlock: 1'b0, host_grant: 1'b0, secure_grant: 1'b0,
                link_sel: CHAC_LINK_OFF, rdata: CHAC_ZERO_BYTE};
    end else begin
      st_r <= st_nxt;
    end
  end

  chac_link_decode u_link_decode (
    .clk_in(REF_CLK_IN),
    .resetn_in(RESETN_IN),
    .link_sel_in(st_r.link_sel),
    .link_en_out(SECURE_MODULE_LINK_EN_OUT)
  );

  assign REG_RDATA_OUT = st_r.rdata;
  assign CMD_CODE_OUT = st_r.cmd;
  assign CMD_START_OUT = st_r.cmd_start;
  assign STANDBY_OUT = st_r.standby;
  assign RADIO_FRONTEND_POWER_DOWN_OUT = st_r.radio_pd;
  assign WRITE_UNLOCK_OUT = st_r.unlock;
  assign HOST_BUS_GRANT_OUT = st_r.host_grant;
  assign SECURE_MODULE_BUS_GRANT_OUT = st_r.secure_grant;

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  standby_entry_a: assert property (
    wr_cmd && REG_WDATA_IN[CHAC_STANDBY_BIT] |=> STANDBY_OUT)
    else $error("standby not entered after write");
  radio_pd_track_a: assert property (
    wr_cmd |=> RADIO_FRONTEND_POWER_DOWN_OUT == $past(REG_WDATA_IN[CHAC_RADIO_PD_BIT]))
    else $error("radio power-down bit not stored");
  cmd_start_a: assert property (
    wr_cmd |=> CMD_START_OUT && CMD_CODE_OUT == $past(REG_WDATA_IN[CHAC_CMD_MSB:CHAC_CMD_LSB]))
    else $error("command write did not start command");
  unlock_once_a: assert property (
    WRITE_UNLOCK_OUT && REG_WR_EN_IN |=> !WRITE_UNLOCK_OUT)
    else $error("unlock survived a write");
  grant_locked_a: assert property (
    !WRITE_UNLOCK_OUT |=> $stable(HOST_BUS_GRANT_OUT) && $stable(SECURE_MODULE_BUS_GRANT_OUT))
    else $error("grant changed without unlock");
  grant_excl_a: assert property (
    !(HOST_BUS_GRANT_OUT && SECURE_MODULE_BUS_GRANT_OUT))
    else $error("both bus grants set");
  host_grant_a: assert property (
    wr_host && WRITE_UNLOCK_OUT && new_host && !new_secure |=> HOST_BUS_GRANT_OUT)
    else $error("host grant not taken");
  secure_grant_a: assert property (
    wr_host && WRITE_UNLOCK_OUT && new_secure && !new_host |=> SECURE_MODULE_BUS_GRANT_OUT)
    else $error("secure module grant not taken");
  reserved_zero_a: assert property (
    REG_RD_EN_IN && REG_ADDR_IN == CHAC_ADDR_HOST_ACCESS |=> REG_RDATA_OUT[4] == 1'b0
      && REG_RDATA_OUT[1:0] == 2'b00)
    else $error("reserved bits read nonzero");
  link_update_a: assert property (
    wr_host && WRITE_UNLOCK_OUT |=>
      st_r.link_sel == $past(REG_WDATA_IN[CHAC_LINK_MSB:CHAC_LINK_LSB]))
    else $error("link select not written under unlock");
  link_locked_a: assert property (
    !WRITE_UNLOCK_OUT |=> $stable(st_r.link_sel))
    else $error("link select changed without unlock");
  unlock_set_a: assert property (
    wr_host && !WRITE_UNLOCK_OUT |=> WRITE_UNLOCK_OUT == $past(REG_WDATA_IN[CHAC_UNLOCK_BIT]))
    else $error("unlock bit not taken from locked write");
  both_refused_a: assert property (
    wr_host && WRITE_UNLOCK_OUT && new_host && new_secure |=>
      $stable(HOST_BUS_GRANT_OUT) && $stable(SECURE_MODULE_BUS_GRANT_OUT))
    else $error("double grant request changed grants");
  start_pulse_a: assert property (
    !wr_cmd |=> !CMD_START_OUT)
    else $error("command start without a write");
  cmd_done_a: assert property (
    CMD_DONE_IN && !wr_cmd |=> CMD_CODE_OUT == CHAC_CMD_IDLE)
    else $error("command field not returned to idle");
  wake_clear_a: assert property (
    WAKE_IN && !wr_cmd |=> !STANDBY_OUT)
    else $error("standby not left on wake");
  cmd_reserved_a: assert property (
    REG_RD_EN_IN && REG_ADDR_IN == CHAC_ADDR_COMMAND |=> REG_RDATA_OUT[5] == 1'b0)
    else $error("command reserved bit read nonzero");
  unmapped_zero_a: assert property (
    REG_RD_EN_IN && REG_ADDR_IN != CHAC_ADDR_COMMAND && REG_ADDR_IN != CHAC_ADDR_HOST_ACCESS
      |=> REG_RDATA_OUT == CHAC_ZERO_BYTE)
    else $error("unmapped read nonzero");
  rdata_hold_a: assert property (
    !REG_RD_EN_IN |=> $stable(REG_RDATA_OUT))
    else $error("read data changed without a read");
  link_en_lag_a: assert property (
    SECURE_MODULE_LINK_EN_OUT == (4'h1 << $past(st_r.link_sel)))
    else $error("link enable does not follow link select");

  unlock_then_grant_c: cover property (
    wr_host && REG_WDATA_IN[CHAC_UNLOCK_BIT] ##[1:4] wr_host && new_host);
  both_refused_c: cover property (wr_host && WRITE_UNLOCK_OUT && new_host && new_secure);
  cmd_done_c: cover property (CMD_START_OUT ##[1:20] CMD_DONE_IN);
  link_i2c_c: cover property (SECURE_MODULE_LINK_EN_OUT[3]);
  wake_c: cover property (WAKE_IN && STANDBY_OUT);
endmodule

/* hw/chac_pkg.sv */
package chac_pkg;
  localparam logic [6:0] CHAC_ADDR_COMMAND = 7'h00;
  localparam logic [6:0] CHAC_ADDR_HOST_ACCESS = 7'h01;
  localparam int CHAC_ADDR_W = 7;
  localparam int CHAC_DATA_W = 8;
  localparam int CHAC_CMD_W = 5;
  // Command register fields
  localparam int CHAC_STANDBY_BIT = 7;
  localparam int CHAC_RADIO_PD_BIT = 6;
  localparam int CHAC_CMD_MSB = 4;
  localparam int CHAC_CMD_LSB = 0;
  // Host access register fields
  localparam int CHAC_UNLOCK_BIT = 7;
  localparam int CHAC_HOST_GRANT_BIT = 6;
  localparam int CHAC_SECURE_GRANT_BIT = 5;
  localparam int CHAC_LINK_MSB = 3;
  localparam int CHAC_LINK_LSB = 2;
  localparam logic [4:0] CHAC_CMD_IDLE = 5'h00;
  localparam logic [7:0] CHAC_ZERO_BYTE = 8'h00;
  typedef enum logic [1:0] {
    CHAC_LINK_OFF = 2'b00,
    CHAC_LINK_SPI = 2'b01,
    CHAC_LINK_LV2W = 2'b10,
    CHAC_LINK_I2C = 2'b11
  } chac_link_type;
endpackage

/* hw/chac_link_decode.sv */
`timescale 1ns/10ps
module chac_link_decode
  import chac_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Selected link
  input wire chac_link_type link_sel_in,
  // One-hot link enables
  output logic [3:0] link_en_out
);
  typedef struct packed {
    logic [3:0] en;
  } chac_dec_state_type;

  chac_dec_state_type st_r;
  chac_dec_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    unique case (link_sel_in)
      CHAC_LINK_OFF: st_nxt.en = 4'h1;
      CHAC_LINK_SPI: st_nxt.en = 4'h2;
      CHAC_LINK_LV2W: st_nxt.en = 4'h4;
      CHAC_LINK_I2C: st_nxt.en = 4'h8;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '{en: 4'h1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link_en_out = st_r.en;

  link_onehot_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $onehot(link_en_out)) else $error("link enables not one-hot");
endmodule

/* verif/chac_host_model.sv */
`timescale 1ns/10ps
module chac_host_model
  import chac_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Register access and status toward the device
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [CHAC_ADDR_W-1:0] addr_out,
  output logic [CHAC_DATA_W-1:0] wdata_out,
  input wire logic [CHAC_DATA_W-1:0] rdata_in,
  output logic done_out,
  output logic wake_out
);
  initial begin
    {wr_en_out, rd_en_out, done_out, wake_out} = 4'h0;
    addr_out = 7'h7F;
    wdata_out = 8'hA5;
  end
  // Idle lines are inverted so the device cannot lean on stale values
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk_in);
    wr_en_out = w;
    rd_en_out = !w;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    q = rdata_in;
    {wr_en_out, rd_en_out} = 2'h0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  // Unlock first, then the protected write
  task automatic prot(input logic [7:0] d);
    logic [7:0] q;
    acc(1'h1, CHAC_ADDR_HOST_ACCESS, 8'h80, q);
    acc(1'h1, CHAC_ADDR_HOST_ACCESS, d, q);
  endtask
  task automatic pulse(input logic wake);
    @(negedge clk_in);
    if (wake) wake_out = 1'h1;
    else done_out = 1'h1;
    @(negedge clk_in);
    {done_out, wake_out} = 2'h0;
  endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import chac_pkg::*;
;
  logic clk, rstn, wr, rd, done, wake, start, stby, rpd, unl, hg, sg;
  logic [6:0] addr;
  logic [7:0] wd, rdat, q;
  logic [4:0] code;
  logic [3:0] len;
  int n_mismatch, total_checks;
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  chac_top dut_u (.REF_CLK_IN(clk), .RESETN_IN(rstn), .REG_WR_EN_IN(wr), .REG_RD_EN_IN(rd),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdat), .CMD_DONE_IN(done),
    .WAKE_IN(wake), .CMD_CODE_OUT(code), .CMD_START_OUT(start), .STANDBY_OUT(stby),
    .RADIO_FRONTEND_POWER_DOWN_OUT(rpd), .WRITE_UNLOCK_OUT(unl), .HOST_BUS_GRANT_OUT(hg),
    .SECURE_MODULE_BUS_GRANT_OUT(sg), .SECURE_MODULE_LINK_EN_OUT(len));
  chac_host_model host_u (.clk_in(clk), .wr_en_out(wr), .rd_en_out(rd), .addr_out(addr),
    .wdata_out(wd), .rdata_in(rdat), .done_out(done), .wake_out(wake));
  function automatic logic [15:0] st();
    return {2'h0, stby, rpd, unl, hg, sg, code, len};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input logic [6:0] a, input logic [7:0] d);
    host_u.acc(1'h1, a, d, q);
  endtask
  task automatic r(input logic [6:0] a, input logic [7:0] e);
    host_u.acc(1'h0, a, 8'h00, q);
    chk("rdata", {8'h00, e}, {8'h00, q});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rstn = 1'h0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rstn = 1'h1;
    chk("outputs", 16'h0001, st());
    r(CHAC_ADDR_COMMAND, 8'h00);
    r(CHAC_ADDR_HOST_ACCESS, 8'h00);
    w(CHAC_ADDR_COMMAND, 8'hE3);
    chk("start", 16'h0001, {15'h0, start});
    chk("outputs", 16'h3031, st());
    r(CHAC_ADDR_COMMAND, 8'hC3);
    chk("start", 16'h0000, {15'h0, start});
    host_u.pulse(1'h0);
    r(CHAC_ADDR_COMMAND, 8'hC0);
    host_u.pulse(1'h1);
    r(CHAC_ADDR_COMMAND, 8'h40);
    w(CHAC_ADDR_COMMAND, 8'h00);
    r(CHAC_ADDR_COMMAND, 8'h00);
    // Locked write changes nothing
    w(CHAC_ADDR_HOST_ACCESS, 8'h64);
    r(CHAC_ADDR_HOST_ACCESS, 8'h00);
    w(CHAC_ADDR_HOST_ACCESS, 8'h80);
    r(CHAC_ADDR_HOST_ACCESS, 8'h80);
    w(CHAC_ADDR_HOST_ACCESS, 8'h57);
    r(CHAC_ADDR_HOST_ACCESS, 8'h44);
    chk("outputs", 16'h0402, st());
    w(CHAC_ADDR_HOST_ACCESS, 8'h20);
    r(CHAC_ADDR_HOST_ACCESS, 8'h44);
    host_u.prot(8'h60);
    r(CHAC_ADDR_HOST_ACCESS, 8'h40);
    for (int k = 0; k < 4; k++) begin
      host_u.prot({3'h1, 1'h0, k[1:0], 2'h0});
      r(CHAC_ADDR_HOST_ACCESS, {3'h1, 1'h0, k[1:0], 2'h0});
      chk("link", {12'h000, 4'h1 << k}, {12'h000, len});
    end
    // Unmapped write still spends the unlock
    w(CHAC_ADDR_HOST_ACCESS, 8'h80);
    w(7'h05, 8'hFF);
    r(7'h05, 8'h00);
    r(CHAC_ADDR_HOST_ACCESS, 8'h2C);
    print_verdict();
  end
endmodule
